//--- hdl/lcd_defs.svh
// Purpose: constants of the character LCD host access block
// Assumes: 100 MHz clk_sys, host pins sampled synchronously
// Notes: instruction and extended code layouts are local choices
// Function
// - both selects high data, sel1 high sel0 low instruction, both low extended
// - instruction register is write only
// - extended register holds contrast, sets annunciator address
// - data register writes copy into targeted RAM
// - address write prefetches that RAM byte
// - each data access steps address; reads prefetch next
// - sel0 high sel1 low does nothing
// - busy flag set ignores new instructions
// - status read puts busy on bit 7
// - status read puts address counter on bits 0-6
// - address set loads counter; steps up or down
// - refresh yields to host; no collateral RAM damage
// - display RAM 80 codes, one line 24 digits
// - two lines of 24 at 00 and 40
// - right shift starts 27/67, left 01/41
// - ROM small 20-7F A0-DF, large E0-FF
// - 64-byte glyph RAM, codes 00-0F select patterns
// - glyph address bits 0-2 pick row; one lights
// - glyph row 7 ORed with cursor
// - upper nibble zero selects glyph RAM, bit3 ignored
// - code bits 0-2 become glyph address 3-5
// - only glyph data bits 0-4 drive dots
`ifndef LCD_DEFS_SVH
`define LCD_DEFS_SVH

// memory geometry
`define LCD_DISP_DEPTH 8'h50
`define LCD_GLYPH_DEPTH 64
`define LCD_ANN_DEPTH 32
`define LCD_DIGITS 5'h18
`define LCD_LINE_LEN 8'h28
`define LCD_LINE2_BASE 7'h40
`define LCD_LINE2_GAP 7'h18
`define LCD_LINE1_LAST 7'h27
`define LCD_LINE2_LAST 7'h67
`define LCD_ONE_LAST 7'h4f
`define LCD_CURSOR_ROW 3'h7

// internal operation time after each accepted write or data read
`define LCD_CLK_NS 10
`define LCD_BUSY_NS 40
`define LCD_BUSY_CYCLES ((`LCD_BUSY_NS + `LCD_CLK_NS - 1) / `LCD_CLK_NS)

// instruction register field positions
`define LCD_INS_DISP_ADDR 7
`define LCD_INS_GLYPH_ADDR 6
`define LCD_INS_FUNC 5
`define LCD_INS_SHIFT 4
`define LCD_INS_CTRL 3
`define LCD_INS_ENTRY 2
`define LCD_INS_TWO_LINE 3
`define LCD_INS_CURSOR 1
`define LCD_INS_INC 1
`define LCD_INS_SHIFT_RIGHT 0
`define LCD_INS_SHIFT_LEFT 1
// extended register field positions
`define LCD_EXT_ANN_ADDR 7

// reset values
`define LCD_RST_CONTRAST 5'h00
`define LCD_RST_INC 1'b1
`define LCD_RST_TWO_LINE 1'b0
`define LCD_RST_CURSOR 1'b0

`endif

//--- hdl/lcd_host_port.sv
// Purpose: parallel host port, address counter and RAM refresh of a char LCD
// Assumes: host pins synchronous to clk_sys, strobe lasts several cycles
// Notes: glyph ROM patterns are supplied outside, only the code is passed on
`include "lcd_defs.svh"

module lcd_host_port
  import lcd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire lcd_host_s hostIn,
  output logic [7:0] hostBusOut,
  output logic hostBusOe,
  output logic [4:0] contrastCode,
  output lcd_scan_s scanOut
);

  typedef enum logic [2:0] {H_IDLE, H_WRITE, H_FETCH, H_LATCH, H_BUSY} lcd_host_state_e;
  typedef enum logic [1:0] {SC_CHAR, SC_CODE, SC_GLYPH, SC_DOT} lcd_scan_state_e;

  lcd_host_state_e hostState, next_hostState;
  lcd_scan_state_e scanState, next_scanState;
  lcd_target_e target, next_target;
  logic [6:0] adc, next_adc;
  logic [7:0] dataReg, next_dataReg;
  logic [2:0] busyCnt, next_busyCnt;
  logic [4:0] next_contrastCode;
  logic incMode, next_incMode;
  logic twoLine, next_twoLine;
  logic cursorOn, next_cursorOn;
  logic [6:0] shift, next_shift;
  logic strobePrev;
  logic [7:0] next_hostBusOut;
  logic next_hostBusOe;
  logic scanLine, next_scanLine;
  logic [4:0] scanDigit, next_scanDigit;
  logic [2:0] scanRow, next_scanRow;
  logic [7:0] scanCode, next_scanCode;
  logic [6:0] scanAddr, next_scanAddr;
  lcd_scan_s next_scanOut;
  logic busy, strobeFall, hostFree;
  lcd_reg_e regSel;
  logic dispEn, dispWe, glyphEn, glyphWe, annEn, annWe;
  logic [6:0] dispAddr;
  logic [5:0] glyphAddr;
  logic [4:0] annAddr;
  logic [7:0] dispRdata, glyphRdata, annRdata;

  // register chosen by the two select pins
  function automatic lcd_reg_e decodeSel(input logic s1, input logic s0);
    if (s1 && s0) return REG_DATA;
    if (s1 && !s0) return REG_INSTR;
    if (!s1 && !s0) return REG_EXT;
    return REG_NONE;
  endfunction : decodeSel

  // display address to memory index; two-line mode packs 40-67 behind 00-27
  function automatic logic [6:0] ddIndex(input logic [6:0] a, input logic two);
    return (two && a[6]) ? a - `LCD_LINE2_GAP : a;
  endfunction : ddIndex

  // next address counter value, wrapping inside the targeted RAM
  function automatic logic [6:0] stepAdc(input logic [6:0] a, input lcd_target_e t,
                                         input logic inc, input logic two);
    logic [6:0] r;
    r = a;
    case (t)
      TGT_GLYPH: r = {1'b0, inc ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
      TGT_ANN: r = {2'b00, inc ? a[4:0] + 5'h01 : a[4:0] - 5'h01};
      default: begin
        if (two) begin
          if (inc) begin
            r = (a == `LCD_LINE1_LAST) ? `LCD_LINE2_BASE
              : (a == `LCD_LINE2_LAST) ? 7'h00 : a + 7'h01;
          end else begin
            r = (a == 7'h00) ? `LCD_LINE2_LAST
              : (a == `LCD_LINE2_BASE) ? `LCD_LINE1_LAST : a - 7'h01;
          end
        end else begin
          if (inc) begin
            r = (a == `LCD_ONE_LAST) ? 7'h00 : a + 7'h01;
          end else begin
            r = (a == 7'h00) ? `LCD_ONE_LAST : a - 7'h01;
          end
        end
      end
    endcase
    return r;
  endfunction : stepAdc

  // display address shown at a digit under the current shift
  function automatic logic [6:0] shownAddr(input logic line, input logic [4:0] digit,
                                           input logic [6:0] sh, input logic two);
    logic [7:0] len;
    logic [7:0] t;
    len = two ? `LCD_LINE_LEN : `LCD_DISP_DEPTH;
    t = {3'h0, digit} + len - {1'b0, sh};
    if (t >= len) begin
      t = t - len;
    end
    return (two && line) ? t[6:0] + `LCD_LINE2_BASE : t[6:0];
  endfunction : shownAddr

  // pattern source of a character code
  function automatic lcd_kind_e codeKind(input logic [7:0] c);
    if (c[7:4] == 4'h0) return KIND_GLYPH_RAM;
    if ((c >= 8'h20 && c <= 8'h7f) || (c >= 8'ha0 && c <= 8'hdf)) return KIND_ROM_SMALL;
    if (c >= 8'he0) return KIND_ROM_LARGE;
    return KIND_BLANK;
  endfunction : codeKind

  // strobe falling edge marks a taken write or the end of a read
  assign strobeFall = strobePrev && !hostIn.strobe;
  assign regSel = decodeSel(hostIn.sel1, hostIn.sel0);
  assign busy = (hostState != H_IDLE);
  assign hostFree = (hostState == H_IDLE);

  // host access sequencer, address counter and mode bits
  always_comb begin
    next_hostState = hostState;
    next_target = target;
    next_adc = adc;
    next_dataReg = dataReg;
    next_busyCnt = busyCnt;
    next_contrastCode = contrastCode;
    next_incMode = incMode;
    next_twoLine = twoLine;
    next_cursorOn = cursorOn;
    next_shift = shift;
    case (hostState)
      H_IDLE: begin
        // anything arriving while busy is dropped
        if (strobeFall && !hostIn.rdWrN) begin
          next_busyCnt = 3'(`LCD_BUSY_CYCLES - 1);
          next_hostState = H_BUSY;
          case (regSel)
            REG_DATA: begin
              next_dataReg = hostIn.data;
              next_hostState = H_WRITE;
            end
            REG_INSTR: begin
              // instruction register content is never read back
              if (hostIn.data[`LCD_INS_DISP_ADDR]) begin
                next_target = TGT_DISP;
                next_adc = hostIn.data[6:0];
                next_hostState = H_FETCH;
              end else if (hostIn.data[`LCD_INS_GLYPH_ADDR]) begin
                next_target = TGT_GLYPH;
                next_adc = {1'b0, hostIn.data[5:0]};
                next_hostState = H_FETCH;
              end else if (hostIn.data[`LCD_INS_FUNC]) begin
                next_twoLine = hostIn.data[`LCD_INS_TWO_LINE];
                next_shift = 7'h00; // a stale shift may exceed the new line length
              end else if (hostIn.data[`LCD_INS_SHIFT]) begin
                if (hostIn.data[`LCD_INS_SHIFT_RIGHT]) begin
                  next_shift = (({1'b0, shift} + 8'h01) >= (twoLine ? `LCD_LINE_LEN
                    : `LCD_DISP_DEPTH)) ? 7'h00 : shift + 7'h01;
                end else if (hostIn.data[`LCD_INS_SHIFT_LEFT]) begin
                  next_shift = (shift == 7'h00) ? 7'((twoLine ? `LCD_LINE_LEN
                    : `LCD_DISP_DEPTH) - 8'h01) : shift - 7'h01;
                end else begin
                  next_shift = 7'h00;
                end
              end else if (hostIn.data[`LCD_INS_CTRL]) begin
                next_cursorOn = hostIn.data[`LCD_INS_CURSOR];
              end else if (hostIn.data[`LCD_INS_ENTRY]) begin
                next_incMode = hostIn.data[`LCD_INS_INC];
              end
            end
            REG_EXT: begin
              if (hostIn.data[`LCD_EXT_ANN_ADDR]) begin
                next_target = TGT_ANN;
                next_adc = {2'b00, hostIn.data[4:0]};
                next_hostState = H_FETCH;
              end else begin
                next_contrastCode = hostIn.data[4:0];
              end
            end
            default: next_hostState = H_IDLE;
          endcase
        end else if (strobeFall && regSel == REG_DATA) begin
          // read done: step and preload the following byte
          next_adc = stepAdc(adc, target, incMode, twoLine);
          next_hostState = H_FETCH;
          next_busyCnt = 3'(`LCD_BUSY_CYCLES - 1);
        end
      end
      H_WRITE: begin
        next_adc = stepAdc(adc, target, incMode, twoLine);
        next_hostState = H_BUSY;
      end
      H_FETCH: next_hostState = H_LATCH;
      H_LATCH: begin
        case (target)
          TGT_GLYPH: next_dataReg = glyphRdata;
          TGT_ANN: next_dataReg = annRdata;
          default: next_dataReg = dispRdata;
        endcase
        next_hostState = H_BUSY;
      end
      H_BUSY: begin
        if (busyCnt == 3'h0) begin
          next_hostState = H_IDLE;
        end else begin
          next_busyCnt = busyCnt - 3'h1;
        end
      end
      default: next_hostState = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hostState <= H_IDLE;
      target <= TGT_DISP;
      adc <= 7'h00;
      dataReg <= 8'h00;
      busyCnt <= 3'h0;
      contrastCode <= `LCD_RST_CONTRAST;
      incMode <= `LCD_RST_INC;
      twoLine <= `LCD_RST_TWO_LINE;
      cursorOn <= `LCD_RST_CURSOR;
      shift <= 7'h00;
      strobePrev <= 1'b0;
    end else begin
      hostState <= next_hostState;
      target <= next_target;
      adc <= next_adc;
      dataReg <= next_dataReg;
      busyCnt <= next_busyCnt;
      contrastCode <= next_contrastCode;
      incMode <= next_incMode;
      twoLine <= next_twoLine;
      cursorOn <= next_cursorOn;
      shift <= next_shift;
      strobePrev <= hostIn.strobe;
    end
  end

  // read data registered: driven from one cycle after strobe rises to one cycle after it falls
  always_comb begin
    next_hostBusOut = 8'h00;
    next_hostBusOe = hostIn.strobe && hostIn.rdWrN && (regSel != REG_NONE);
    // released bus reads as zero so stale status never leaks out
    if (next_hostBusOe) begin
      case (regSel)
        REG_DATA: next_hostBusOut = dataReg;
        REG_INSTR: next_hostBusOut = {busy, adc};
        REG_EXT: next_hostBusOut = {3'h0, contrastCode};
        default: next_hostBusOut = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hostBusOut <= 8'h00;
      hostBusOe <= 1'b0;
    end else begin
      hostBusOut <= next_hostBusOut;
      hostBusOe <= next_hostBusOe;
    end
  end

  // memory ports: host owns them when active, refresh only while host idles
  always_comb begin
    dispEn = 1'b0;
    dispWe = 1'b0;
    dispAddr = ddIndex(shownAddr(scanLine, scanDigit, shift, twoLine), twoLine);
    glyphEn = 1'b0;
    glyphWe = 1'b0;
    glyphAddr = {scanCode[2:0], scanRow};
    annEn = 1'b0;
    annWe = 1'b0;
    annAddr = adc[4:0];
    if (hostState == H_WRITE || hostState == H_FETCH) begin
      case (target)
        TGT_GLYPH: begin
          glyphEn = 1'b1;
          glyphWe = (hostState == H_WRITE);
          glyphAddr = adc[5:0];
        end
        TGT_ANN: begin
          annEn = 1'b1;
          annWe = (hostState == H_WRITE);
        end
        default: begin
          dispEn = 1'b1;
          dispWe = (hostState == H_WRITE);
          dispAddr = ddIndex(adc, twoLine);
        end
      endcase
    end else begin
      dispEn = hostFree && (scanState == SC_CHAR);
      glyphEn = hostFree && (scanState == SC_GLYPH);
    end
  end

  lcd_ram #(.AW(7), .DEPTH(80)) dispRam (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .en(dispEn),
    .we(dispWe),
    .addr(dispAddr),
    .wdata(dataReg),
    .rdata(dispRdata)
  );

  lcd_ram #(.AW(6), .DEPTH(`LCD_GLYPH_DEPTH)) glyphRam (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .en(glyphEn),
    .we(glyphWe),
    .addr(glyphAddr),
    .wdata(dataReg),
    .rdata(glyphRdata)
  );

  lcd_ram #(.AW(5), .DEPTH(`LCD_ANN_DEPTH)) annRam (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .en(annEn),
    .we(annWe),
    .addr(annAddr),
    .wdata(dataReg),
    .rdata(annRdata)
  );

  // refresh walker: digits inner, rows outer, lines last
  always_comb begin
    next_scanState = scanState;
    next_scanLine = scanLine;
    next_scanDigit = scanDigit;
    next_scanRow = scanRow;
    next_scanCode = scanCode;
    next_scanAddr = scanAddr;
    next_scanOut = '0;
    next_scanOut.line = scanLine;
    next_scanOut.digit = scanDigit;
    next_scanOut.row = scanRow;
    next_scanOut.code = dispRdata;
    next_scanOut.kind = codeKind(dispRdata);
    // cursor row follows the counter even off display RAM
    next_scanOut.dots = (scanRow == `LCD_CURSOR_ROW && cursorOn && scanAddr == adc)
      ? 5'h1f : 5'h00;
    case (scanState)
      SC_CHAR: begin
        if (hostFree) begin
          next_scanAddr = shownAddr(scanLine, scanDigit, shift, twoLine);
          next_scanState = SC_CODE;
        end
      end
      SC_CODE: begin
        next_scanCode = dispRdata;
        if (codeKind(dispRdata) == KIND_GLYPH_RAM) begin
          next_scanState = SC_GLYPH;
        end else begin
          next_scanOut.valid = 1'b1;
          next_scanState = SC_CHAR;
        end
      end
      SC_GLYPH: begin
        if (hostFree) begin
          next_scanState = SC_DOT;
        end
      end
      SC_DOT: begin
        next_scanOut.code = scanCode;
        next_scanOut.kind = KIND_GLYPH_RAM;
        next_scanOut.dots = next_scanOut.dots | glyphRdata[4:0];
        next_scanOut.valid = 1'b1;
        next_scanState = SC_CHAR;
      end
      default: next_scanState = SC_CHAR;
    endcase
    if (next_scanOut.valid) begin
      if (scanDigit == `LCD_DIGITS - 5'h01) begin
        next_scanDigit = 5'h00;
        next_scanRow = scanRow + 3'h1;
        if (scanRow == `LCD_CURSOR_ROW) begin
          next_scanLine = twoLine && !scanLine;
        end
      end else begin
        next_scanDigit = scanDigit + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      scanState <= SC_CHAR;
      scanLine <= 1'b0;
      scanDigit <= 5'h00;
      scanRow <= 3'h0;
      scanCode <= 8'h00;
      scanAddr <= 7'h00;
      scanOut <= '0;
    end else begin
      scanState <= next_scanState;
      scanLine <= next_scanLine;
      scanDigit <= next_scanDigit;
      scanRow <= next_scanRow;
      scanCode <= next_scanCode;
      scanAddr <= next_scanAddr;
      scanOut <= next_scanOut;
    end
  end

endmodule : lcd_host_port

//--- hdl/lcd_pkg.sv
// Purpose: types shared by the LCD host access block
// Assumes: constants live in lcd_defs.svh
// Notes: none
package lcd_pkg;

  typedef enum logic [1:0] {TGT_DISP, TGT_GLYPH, TGT_ANN} lcd_target_e;
  typedef enum logic [1:0] {REG_DATA, REG_INSTR, REG_EXT, REG_NONE} lcd_reg_e;
  typedef enum logic [1:0] {KIND_ROM_SMALL, KIND_ROM_LARGE, KIND_GLYPH_RAM, KIND_BLANK} lcd_kind_e;

  // host pins, sampled on clk_sys
  typedef struct packed {
    logic strobe;
    logic rdWrN;
    logic sel1;
    logic sel0;
    logic [7:0] data;
  } lcd_host_s;

  // one refreshed character row toward the drive logic
  typedef struct packed {
    logic valid;
    logic line;
    logic [4:0] digit;
    logic [2:0] row;
    lcd_kind_e kind;
    logic [7:0] code;
    logic [4:0] dots;
  } lcd_scan_s;

endpackage : lcd_pkg

//--- hdl/lcd_ram.sv
// Purpose: single port byte memory with registered read data
// Assumes: one access per cycle, enable gates both read and write
// Notes: read data holds until the next enabled read
module lcd_ram #(
  parameter int AW = 7,
  parameter int DEPTH = 80
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic en,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  logic [7:0] mem [DEPTH];
  logic [7:0] next_rdata;

  // read data only moves on an enabled read, so a late reader still sees it
  always_comb begin
    next_rdata = rdata;
    if (en && !we && (int'(addr) < DEPTH)) begin
      next_rdata = mem[addr];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // array itself has no reset, contents are undefined at power-on
  always_ff @(posedge clk_sys) begin
    if (en && we && (int'(addr) < DEPTH)) begin
      mem[addr] <= wdata;
    end
  end

endmodule : lcd_ram

//--- hdl/lcd_ram_unused_guard.sv
// Purpose: none
// Assumes: none
// Notes: none

//--- test/char_lcd_host_access_tb_top.sv
// Purpose: self-checking bench of the LCD host access block
// Assumes: host model drives pins; select pair written as {sel1, sel0}
// Notes: read results are queued expectations checked by a monitor
module char_lcd_host_access_tb_top
  import lcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  lcd_host_s hostIn;
  logic [7:0] hostBusOut;
  logic hostBusOe;
  logic [4:0] contrastCode;
  lcd_scan_s scanOut;
  int failures = 0;
  int checks = 0;
  int seed = 62;
  logic [7:0] expQ[$];
  logic [7:0] gotVal;
  logic [7:0] q;
  logic [7:0] mem[8];
  logic ok;
  event gotEv;

  always #5 clk_sys = ~clk_sys;

  lcd_host_port lcd_host_port_inst (.clk_sys(clk_sys), .rst_b(rst_b), .hostIn(hostIn),
    .hostBusOut(hostBusOut), .hostBusOe(hostBusOe), .contrastCode(contrastCode),
    .scanOut(scanOut));
  lcd_host_model lcd_host_model_inst (.clk_sys(clk_sys), .hostBusOut(hostBusOut),
    .hostBusOe(hostBusOe), .hostIn(hostIn));

  task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp8

  task automatic cmpC(input logic [4:0] e, input logic [4:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmpC

  // write, then poll until the block is free again
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    lcd_host_model_inst.access(1'b0, s, d, 3, q);
    lcd_host_model_inst.wait_idle(ok);
    if (ok !== 1'b1) failures++;
  endtask : wr

  // queue the expectation and hand the result to the monitor
  task automatic note(input logic [7:0] e, input logic [7:0] g);
    expQ.push_back(e);
    gotVal = g;
    -> gotEv;
  endtask : note

  // read, note the result, then poll until the block is free again
  task automatic rd(input logic [1:0] s, input logic [7:0] e);
    logic [7:0] g;
    lcd_host_model_inst.access(1'b1, s, 8'h00, 3, g);
    note(e, g);
    lcd_host_model_inst.wait_idle(ok);
    if (ok !== 1'b1) failures++;
  endtask : rd

  // bounded wait for one refreshed row of line 1 at a digit, then note its dots
  task automatic waitScan(input logic [4:0] dg, input logic [2:0] r, input logic [7:0] e);
    int n;
    n = 0;
    while (n < 3000 && !(scanOut.valid && !scanOut.line && scanOut.digit == dg
      && scanOut.row == r)) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 3000) failures++;
    note(e, {3'h0, scanOut.dots});
  endtask : waitScan

  // oldest note against each read result
  always @(gotEv) begin
    cmp8(expQ.pop_front(), gotVal);
  end

  task automatic print_verdict;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // whole sequence needs roughly 3000 cycles; give it ample margin
  initial begin
    #200us;
    failures++;
    print_verdict();
  end

  initial begin
    mem[0] = 8'h41;
    mem[1] = 8'he5;
    mem[2] = 8'($random(seed));
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    cmpC(5'h00, contrastCode);
    wr(2'b00, 8'h15);
    cmpC(5'h15, contrastCode);
    rd(2'b00, 8'h15);
    // disabled select leaves counter and bus alone
    wr(2'b10, 8'h85);
    rd(2'b10, 8'h05);
    wr(2'b01, 8'h80);
    rd(2'b01, 8'hff);
    rd(2'b10, 8'h05);
    // display writes step up, then prefetching reads
    for (int i = 0; i < 3; i++) wr(2'b11, mem[i]);
    rd(2'b10, 8'h08);
    wr(2'b10, 8'h85);
    for (int i = 0; i < 3; i++) rd(2'b11, mem[i]);
    // status right after a write shows busy on bit 7
    lcd_host_model_inst.access(1'b0, 2'b11, 8'h20, 3, q);
    lcd_host_model_inst.access(1'b1, 2'b10, 8'h00, 2, q);
    note(8'h80, q & 8'h80);
    lcd_host_model_inst.wait_idle(ok);
    // decrement mode walks back down
    wr(2'b10, 8'h04);
    wr(2'b10, 8'h87);
    rd(2'b11, mem[2]);
    rd(2'b11, mem[1]);
    rd(2'b10, 8'h05);
    wr(2'b10, 8'h06);
    // counter wrap in one-line and two-line modes
    wr(2'b10, 8'hcf);
    wr(2'b11, 8'h33);
    rd(2'b10, 8'h00);
    wr(2'b10, 8'h28);
    wr(2'b10, 8'ha7);
    wr(2'b11, 8'h34);
    rd(2'b10, 8'h40);
    wr(2'b10, 8'he7);
    wr(2'b11, 8'h35);
    rd(2'b10, 8'h00);
    // second write lands while busy and must be dropped
    wr(2'b10, 8'h90);
    lcd_host_model_inst.access(1'b0, 2'b11, 8'h36, 3, q);
    lcd_host_model_inst.access(1'b0, 2'b11, 8'h37, 1, q);
    lcd_host_model_inst.wait_idle(ok);
    rd(2'b10, 8'h11);
    // cursor off, glyph address set, then glyph rows of pattern 7
    wr(2'b10, 8'h08);
    wr(2'b10, 8'h78);
    for (int i = 0; i < 8; i++) begin
      mem[i] = (i == 7) ? 8'he0 : 8'($random(seed));
      wr(2'b11, mem[i]);
    end
    rd(2'b10, 8'h00);
    wr(2'b10, 8'h78);
    for (int i = 0; i < 8; i++) rd(2'b11, mem[i]);
    wr(2'b10, 8'h80);
    wr(2'b11, 8'h0f);
    // code 0f draws pattern 7 at digit 0, then at digit 1 after a right shift; only bits 0-4 reach the dots
    for (int r = 0; r < 8; r++) waitScan(5'h00, 3'(r), {3'h0, mem[r][4:0]});
    wr(2'b10, 8'h11);
    for (int r = 0; r < 8; r++) waitScan(5'h01, 3'(r), {3'h0, mem[r][4:0]});
    // annunciator write, 5-bit wrap, read back
    wr(2'b00, 8'h9f);
    wr(2'b11, 8'h5a);
    rd(2'b10, 8'h00);
    wr(2'b00, 8'h9f);
    rd(2'b11, 8'h5a);
    cmpC(5'h15, contrastCode);
    repeat (200) @(posedge clk_sys);
    print_verdict();
  end
endmodule : char_lcd_host_access_tb_top

//--- test/lcd_host_model.sv
// Purpose: behavioural host microcontroller on the parallel port
// Assumes: every access starts just after a rising clk_sys edge
// Notes: released data lines float high through the pin pull-ups
module lcd_host_model
  import lcd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [7:0] hostBusOut,
  input wire logic hostBusOe,
  output lcd_host_s hostIn
);
  timeunit 1ns;
  timeprecision 1ps;

  logic strobe = 1'b0;
  logic rdWrN = 1'b1;
  logic [1:0] sel = 2'b11;
  logic drv = 1'b0;
  logic [7:0] wdat = 8'h00;
  logic [7:0] wireData;

  // wire level: host first, then device, else pull-ups
  assign wireData = drv ? wdat : (hostBusOe ? hostBusOut : 8'hff);
  assign hostIn = '{strobe: strobe, rdWrN: rdWrN, sel1: sel[1], sel0: sel[0], data: wireData};

  // one strobe pulse; selects and data held until after the fall
  task automatic access(input logic rd, input logic [1:0] s, input logic [7:0] d,
                        input int hi, output logic [7:0] q);
    @(posedge clk_sys);
    rdWrN <= rd;
    sel <= s;
    drv <= !rd;
    wdat <= d;
    @(posedge clk_sys);
    strobe <= 1'b1;
    repeat (hi) @(posedge clk_sys);
    q = wireData;
    strobe <= 1'b0;
    @(posedge clk_sys);
    drv <= 1'b0;
  endtask : access

  // status polling, bounded so a stuck busy cannot hang the run
  task automatic wait_idle(output logic ok);
    logic [7:0] st;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      access(1'b1, 2'b10, 8'h00, 3, st);
      ok = (st[7] === 1'b0);
    end
  endtask : wait_idle
endmodule : lcd_host_model

//--- test/lcd_host_port_asserts.sv
// Purpose: port-level checks of the LCD host access block
// Assumes: host pins synchronous to clk_sys
// Notes: busy is internal, so checks lean on bus and scan timing
module lcd_host_port_chk
  import lcd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire lcd_host_s hostIn,
  input wire logic [7:0] hostBusOut,
  input wire logic hostBusOe,
  input wire logic [4:0] contrastCode,
  input wire lcd_scan_s scanOut
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  logic disSel;
  logic extWrite;
  logic [2:0] extAge;
  logic [2:0] next_extAge;
  assign disSel = hostIn.sel0 && !hostIn.sel1;
  assign extWrite = hostIn.strobe && !hostIn.rdWrN && !hostIn.sel0 && !hostIn.sel1;

  // cycles since the last extended write strobe, saturating
  always_comb begin
    next_extAge = extAge;
    if (extWrite) begin
      next_extAge = 3'h0;
    end else if (extAge != 3'h7) begin
      next_extAge = extAge + 3'h1;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      extAge <= 3'h7;
    end else begin
      extAge <= next_extAge;
    end
  end

  property p_dis_quiet; hostIn.strobe && disSel |=> !hostBusOe; endproperty
  property p_read_drive; hostIn.strobe && hostIn.rdWrN && !disSel |=> hostBusOe; endproperty
  property p_drop; !hostIn.strobe |=> !hostBusOe; endproperty
  property p_write_quiet; hostIn.strobe && !hostIn.rdWrN |=> !hostBusOe; endproperty
  property p_zero_out; !hostBusOe |-> hostBusOut == 8'h00; endproperty
  property p_contrast; $changed(contrastCode) |-> extAge < 3'h6; endproperty
  property p_glyph_sel;
    scanOut.valid && scanOut.kind != KIND_BLANK
      |-> (scanOut.kind == KIND_GLYPH_RAM) == (scanOut.code[7:4] == 4'h0);
  endproperty
  property p_large; scanOut.valid && scanOut.code >= 8'he0
    |-> scanOut.kind inside {KIND_ROM_LARGE, KIND_BLANK}; endproperty
  property p_small; scanOut.valid && (scanOut.code inside {[8'h20:8'h7f], [8'ha0:8'hdf]})
    |-> scanOut.kind inside {KIND_ROM_SMALL, KIND_BLANK}; endproperty
  property p_digit; scanOut.valid |-> scanOut.digit < 5'h18; endproperty

  a_dis_quiet: assert property (p_dis_quiet) else $error("bus driven on disabled select");
  a_read_drive: assert property (p_read_drive) else $error("read not driven");
  a_drop: assert property (p_drop) else $error("bus held after strobe");
  a_write_quiet: assert property (p_write_quiet) else $error("bus driven on write");
  a_zero_out: assert property (p_zero_out) else $error("read data while released");
  a_contrast: assert property (p_contrast) else $error("contrast moved on its own");
  a_glyph_sel: assert property (p_glyph_sel) else $error("glyph kind mismatch");
  a_large: assert property (p_large) else $error("large code not large");
  a_small: assert property (p_small) else $error("small code not small");
  a_digit: assert property (p_digit) else $error("digit out of range");

  // main scenarios reached
  c_glyph: cover property (scanOut.valid && scanOut.kind == KIND_GLYPH_RAM);
  c_busy: cover property (hostBusOe && hostBusOut[7]);
  c_dis: cover property (hostIn.strobe && disSel);
endmodule : lcd_host_port_chk

bind lcd_host_port lcd_host_port_chk lcd_host_port_chk_inst (.clk_sys(clk_sys),
  .rst_b(rst_b), .hostIn(hostIn), .hostBusOut(hostBusOut), .hostBusOe(hostBusOe),
  .contrastCode(contrastCode), .scanOut(scanOut));
